// File: rpm_pin_mux.sv
`timescale 1ns/100ps
// Notes on behaviour
// (R1) Each pin has its own 6-bit select
// (R2) Reset clears selects; pin uses port function
// (R3) Codes 1, 3 pick UART A, B transmit
// (R4) Codes 8-10 pick SPI B outputs
// (R5) Codes 11-13 pick codec outputs
// (R6) Codes 14, 15 pick CAN A, B transmit
// (R7) Codes 16-23 pick compare channels 1-8
// (R8) Codes 24-26, 50, 51 pick comparators 1-5
// (R9) Codes 27-30 pick UART C, D outputs
// (R10) Codes 31-33 pick SPI C outputs
// (R11) Codes 45, 46 pick PWM sync outputs
// (R12) Codes 47-49 pick encoder matches, reference clock
// (R13) No lockouts between any selections
// (R14) Voltage alarm tri-states every pin
// (R15) Reset puts shared pins in analog mode
// (R16) Only analog select gates digital input
// (R17) Higher priority function blocks lower ones
// (R18) At most one output drives a pin
// (R19) Dedicated output beats remappable output
// (R20) Many inputs may sample one pin
// (R21) Active output enables driver despite direction
// (R22) Input mapping leaves direction untouched
// (R23) Unassigned codes behave as null
// (R24) Select change reaches pin next cycle
module rpm_pin_mux
  import rpm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Select field writes
  input wire logic [rpm_pkg::NUM_PINS-1:0] selWrite,
  input wire logic [rpm_pkg::CODE_W-1:0] selData,
  // Port register writes
  input wire logic dirWrite,
  input wire logic [rpm_pkg::NUM_PINS-1:0] dirData,
  input wire logic analogWrite,
  input wire logic [rpm_pkg::NUM_PINS-1:0] analogData,
  input wire logic latchWrite,
  input wire logic [rpm_pkg::NUM_PINS-1:0] latchData,
  // Peripheral and dedicated outputs
  input wire rpm_pkg::rpm_periph_t periph,
  input wire rpm_pkg::rpm_ded_t [rpm_pkg::NUM_PINS-1:0] dedicated,
  // Asynchronous pin side
  input wire logic highCoreVoltageDetect,
  input wire logic [rpm_pkg::NUM_PINS-1:0] pinIn,
  // Pin drive
  output logic [rpm_pkg::NUM_PINS-1:0] pinOut,
  output logic [rpm_pkg::NUM_PINS-1:0] pinOe,
  // Readback and inputs to peripherals
  output logic [rpm_pkg::NUM_PINS*rpm_pkg::CODE_W-1:0] selCodes,
  output logic [rpm_pkg::NUM_PINS-1:0] pinDirection,
  output logic [rpm_pkg::NUM_PINS-1:0] analogSelect,
  output logic [rpm_pkg::NUM_PINS-1:0] outputLatch,
  output logic [rpm_pkg::NUM_PINS-1:0] pinLevel,
  output logic [rpm_pkg::NUM_PINS-1:0] digitalIn,
  output logic ioDisabled
);
  import rpm_pkg::*;

  logic [CODE_W-1:0] selCode_ff [NUM_PINS];
  logic [NUM_PINS-1:0] dir_ff;
  logic [NUM_PINS-1:0] analog_ff;
  logic [NUM_PINS-1:0] latch_ff;
  logic [NUM_PINS-1:0] pinSync1_ff;
  logic [NUM_PINS-1:0] pinSync2_ff;
  logic hvdSync1_ff;
  logic hvdSync2_ff;
  logic [NUM_PINS-1:0] pinOut_ff;
  logic [NUM_PINS-1:0] pinOe_ff;
  logic [NUM_PINS-1:0] pinLevel_ff;
  logic [NUM_PINS-1:0] digitalIn_ff;
  logic ioDisabled_ff;
  logic [NUM_PINS-1:0] outputLatch_ff;
  logic [NUM_PINS-1:0] remapActive;
  logic [NUM_PINS-1:0] remapLevel;
  rpm_drive_t nxt_drive [NUM_PINS];

  // Highest enabled dedicated function, index 0 first
  function automatic rpm_drive_t pick_dedicated(input rpm_ded_t d);
    rpm_drive_t r;
    r.out = 1'b0;
    r.oe = 1'b0;
    for (int k = NUM_DED - 1; k >= 0; k--) begin
      if (d.enable[k]) begin
        r.out = d.level[k]; // [R17]
        r.oe = 1'b1;
      end
    end
    return r;
  endfunction

  // Select fields, one per pin, no cross checks
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!resetn) begin
        selCode_ff[i] <= CODE_RST; // [R2]
      end else if (selWrite[i]) begin
        selCode_ff[i] <= selData; // [R1] [R13]
      end
    end
  end

  // Direction register; input mapping never touches it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dir_ff <= {NUM_PINS{DIR_RST}};
    end else if (dirWrite) begin
      dir_ff <= dirData; // [R22]
    end
  end

  // Analog select comes up set on every reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      analog_ff <= {NUM_PINS{ANALOG_RST}}; // [R15]
    end else if (analogWrite) begin
      analog_ff <= analogData; // [R16]
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      latch_ff <= {NUM_PINS{LATCH_RST}};
    end else if (latchWrite) begin
      latch_ff <= latchData;
    end
  end

  // Two-stage synchronisers for pins and alarm
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pinSync1_ff <= '0;
      pinSync2_ff <= '0;
      hvdSync1_ff <= 1'b0;
      hvdSync2_ff <= 1'b0;
    end else begin
      pinSync1_ff <= pinIn;
      pinSync2_ff <= pinSync1_ff;
      hvdSync1_ff <= highCoreVoltageDetect;
      hvdSync2_ff <= hvdSync1_ff;
    end
  end

  for (genvar g = 0; g < NUM_PINS; g++) begin : gPin
    rpm_code_mux uMux (
      .code(selCode_ff[g]),
      .periph(periph),
      .active(remapActive[g]),
      .level(remapLevel[g])
    );
  end

  // One source per pin: dedicated, remapped, then port latch
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      nxt_drive[i] = pick_dedicated(dedicated[i]);
      if (!nxt_drive[i].oe) begin
        if (remapActive[i]) begin
          nxt_drive[i].out = remapLevel[i]; // [R18] [R19]
          nxt_drive[i].oe = 1'b1; // [R21]
        end else begin
          nxt_drive[i].out = latch_ff[i];
          nxt_drive[i].oe = !dir_ff[i]; // [R21]
        end
      end
    end
  end

  // Registered drive; alarm forces every pin off
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!resetn || hvdSync2_ff) begin
        pinOut_ff[i] <= 1'b0;
        pinOe_ff[i] <= 1'b0; // [R14]
      end else begin
        pinOut_ff[i] <= nxt_drive[i].out; // [R24]
        pinOe_ff[i] <= nxt_drive[i].oe;
      end
    end
  end

  // Digital input gated by analog select only, not direction
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      digitalIn_ff <= '0;
      pinLevel_ff <= '0;
    end else begin
      digitalIn_ff <= pinSync2_ff & ~analog_ff; // [R16] [R20]
      pinLevel_ff <= pinSync2_ff & ~analog_ff; // [R15]
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ioDisabled_ff <= 1'b0;
    end else begin
      ioDisabled_ff <= hvdSync2_ff; // [R14]
    end
  end

  // Latch readback reads zero on analog pins; one cycle behind a write
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      outputLatch_ff <= {NUM_PINS{LATCH_RST}};
    end else begin
      outputLatch_ff <= latch_ff & ~analog_ff; // [R15]
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      selCodes[i*CODE_W +: CODE_W] = selCode_ff[i];
    end
  end

  assign pinOut = pinOut_ff;
  assign pinOe = pinOe_ff;
  assign pinDirection = dir_ff;
  assign analogSelect = analog_ff;
  assign outputLatch = outputLatch_ff;
  assign pinLevel = pinLevel_ff;
  assign digitalIn = digitalIn_ff;
  assign ioDisabled = ioDisabled_ff;

endmodule

// File: rpm_pkg.sv
package rpm_pkg;

  // Pin count and field widths
  localparam int NUM_PINS = 8;
  localparam int CODE_W = 6;
  localparam int NUM_DED = 2;

  // Select codes
  localparam logic [5:0] CODE_NULL = 6'h00;
  localparam logic [5:0] CODE_UART_A_TX = 6'h01;
  localparam logic [5:0] CODE_UART_B_TX = 6'h03;
  localparam logic [5:0] CODE_SPI_B_DATA = 6'h08;
  localparam logic [5:0] CODE_SPI_B_CLK = 6'h09;
  localparam logic [5:0] CODE_SPI_B_SEL = 6'h0a;
  localparam logic [5:0] CODE_CODEC_DATA = 6'h0b;
  localparam logic [5:0] CODE_CODEC_CLK = 6'h0c;
  localparam logic [5:0] CODE_CODEC_FS = 6'h0d;
  localparam logic [5:0] CODE_CAN_A_TX = 6'h0e;
  localparam logic [5:0] CODE_CAN_B_TX = 6'h0f;
  localparam logic [5:0] CODE_CMP_OUT_LO = 6'h10;
  localparam logic [5:0] CODE_CMP_OUT_HI = 6'h17;
  localparam logic [5:0] CODE_CMPR_1 = 6'h18;
  localparam logic [5:0] CODE_CMPR_2 = 6'h19;
  localparam logic [5:0] CODE_CMPR_3 = 6'h1a;
  localparam logic [5:0] CODE_UART_C_TX = 6'h1b;
  localparam logic [5:0] CODE_UART_C_RTS = 6'h1c;
  localparam logic [5:0] CODE_UART_D_TX = 6'h1d;
  localparam logic [5:0] CODE_UART_D_RTS = 6'h1e;
  localparam logic [5:0] CODE_SPI_C_DATA = 6'h1f;
  localparam logic [5:0] CODE_SPI_C_CLK = 6'h20;
  localparam logic [5:0] CODE_SPI_C_SEL = 6'h21;
  localparam logic [5:0] CODE_PWM_SYNC_PRI = 6'h2d;
  localparam logic [5:0] CODE_PWM_SYNC_SEC = 6'h2e;
  localparam logic [5:0] CODE_ENC_A_MATCH = 6'h2f;
  localparam logic [5:0] CODE_ENC_B_MATCH = 6'h30;
  localparam logic [5:0] CODE_REF_CLK = 6'h31;
  localparam logic [5:0] CODE_CMPR_4 = 6'h32;
  localparam logic [5:0] CODE_CMPR_5 = 6'h33;

  // Reset values
  localparam logic [5:0] CODE_RST = 6'h00;
  localparam logic ANALOG_RST = 1'b1;
  localparam logic DIR_RST = 1'b1;
  localparam logic LATCH_RST = 1'b0;

  // Peripheral output group
  typedef struct packed {
    logic uartATransmit;
    logic uartBTransmit;
    logic uartCTransmit;
    logic uartCReadyToSend;
    logic uartDTransmit;
    logic uartDReadyToSend;
    logic spiBDataOut;
    logic spiBClockOut;
    logic spiBSelectOut;
    logic spiCDataOut;
    logic spiCClockOut;
    logic spiCSelectOut;
    logic codecDataOut;
    logic codecClockOut;
    logic codecFrameSyncOut;
    logic canATransmit;
    logic canBTransmit;
    logic [7:0] compareOut;
    logic [4:0] comparatorOut;
    logic pwmPrimarySyncOut;
    logic pwmSecondarySyncOut;
    logic encoderACountMatchOut;
    logic encoderBCountMatchOut;
    logic referenceClockOut;
  } rpm_periph_t;

  // Dedicated function request per pin, in priority order
  typedef struct packed {
    logic [NUM_DED-1:0] enable;
    logic [NUM_DED-1:0] level;
  } rpm_ded_t;

  // Per pin drive result
  typedef struct packed {
    logic out;
    logic oe;
  } rpm_drive_t;

endpackage

// File: rpm_code_mux.sv
`timescale 1ns/100ps
module rpm_code_mux
  import rpm_pkg::*;
(
  // Selection
  input wire logic [rpm_pkg::CODE_W-1:0] code,
  input wire rpm_pkg::rpm_periph_t periph,
  // Result
  output logic active,
  output logic level
);
  import rpm_pkg::*;

  always_comb begin
    active = 1'b1;
    level = 1'b0;
    case (code) // [R1]
      CODE_UART_A_TX: level = periph.uartATransmit; // [R3]
      CODE_UART_B_TX: level = periph.uartBTransmit; // [R3]
      CODE_SPI_B_DATA: level = periph.spiBDataOut; // [R4]
      CODE_SPI_B_CLK: level = periph.spiBClockOut; // [R4]
      CODE_SPI_B_SEL: level = periph.spiBSelectOut; // [R4]
      CODE_CODEC_DATA: level = periph.codecDataOut; // [R5]
      CODE_CODEC_CLK: level = periph.codecClockOut; // [R5]
      CODE_CODEC_FS: level = periph.codecFrameSyncOut; // [R5]
      CODE_CAN_A_TX: level = periph.canATransmit; // [R6]
      CODE_CAN_B_TX: level = periph.canBTransmit; // [R6]
      CODE_CMPR_1: level = periph.comparatorOut[0]; // [R8]
      CODE_CMPR_2: level = periph.comparatorOut[1]; // [R8]
      CODE_CMPR_3: level = periph.comparatorOut[2]; // [R8]
      CODE_CMPR_4: level = periph.comparatorOut[3]; // [R8]
      CODE_CMPR_5: level = periph.comparatorOut[4]; // [R8]
      CODE_UART_C_TX: level = periph.uartCTransmit; // [R9]
      CODE_UART_C_RTS: level = periph.uartCReadyToSend; // [R9]
      CODE_UART_D_TX: level = periph.uartDTransmit; // [R9]
      CODE_UART_D_RTS: level = periph.uartDReadyToSend; // [R9]
      CODE_SPI_C_DATA: level = periph.spiCDataOut; // [R10]
      CODE_SPI_C_CLK: level = periph.spiCClockOut; // [R10]
      CODE_SPI_C_SEL: level = periph.spiCSelectOut; // [R10]
      CODE_PWM_SYNC_PRI: level = periph.pwmPrimarySyncOut; // [R11]
      CODE_PWM_SYNC_SEC: level = periph.pwmSecondarySyncOut; // [R11]
      CODE_ENC_A_MATCH: level = periph.encoderACountMatchOut; // [R12]
      CODE_ENC_B_MATCH: level = periph.encoderBCountMatchOut; // [R12]
      CODE_REF_CLK: level = periph.referenceClockOut; // [R12]
      default: begin
        // Compare channels occupy one contiguous span
        if (code >= CODE_CMP_OUT_LO && code <= CODE_CMP_OUT_HI) begin
          level = periph.compareOut[code[2:0]]; // [R7]
        end else begin
          active = 1'b0; // [R2] [R23]
        end
      end
    endcase
  end

endmodule

// File: rpm_pin_mux_properties.sv
`timescale 1ns/100ps
module rpm_pin_mux_properties
  import rpm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Stimulus
  input wire logic [rpm_pkg::NUM_PINS-1:0] selWrite,
  input wire logic [rpm_pkg::CODE_W-1:0] selData,
  input wire rpm_pkg::rpm_periph_t periph,
  input wire rpm_pkg::rpm_ded_t [rpm_pkg::NUM_PINS-1:0] dedicated,
  input wire logic highCoreVoltageDetect,
  // Results
  input wire logic [rpm_pkg::NUM_PINS-1:0] pinOut,
  input wire logic [rpm_pkg::NUM_PINS-1:0] pinOe,
  input wire logic [rpm_pkg::NUM_PINS*rpm_pkg::CODE_W-1:0] selCodes,
  input wire logic [rpm_pkg::NUM_PINS-1:0] pinDirection,
  input wire logic [rpm_pkg::NUM_PINS-1:0] analogSelect,
  input wire logic [rpm_pkg::NUM_PINS-1:0] digitalIn,
  input wire logic ioDisabled
);
  import rpm_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_SEL_LOAD: assert property (
    selWrite[3] |=> selCodes[23:18] == $past(selData))
    else $error("select field not loaded");
  AST_RST_CLEAR: assert property (disable iff (1'b0)
    !resetn |=> selCodes == '0 && analogSelect == '1)
    else $error("reset state wrong");
  AST_HVD_TRI: assert property (
    highCoreVoltageDetect [*4] |-> pinOe == '0)
    else $error("pins driven during alarm");
  AST_HVD_FLAG: assert property (ioDisabled |-> pinOe == '0)
    else $error("alarm flag without tri-state");
  AST_HVD_CLEAR: assert property (
    !highCoreVoltageDetect [*4] |-> !ioDisabled)
    else $error("alarm flag stuck");
  AST_DED_WINS: assert property (
    (dedicated[0].enable[0] && !highCoreVoltageDetect) [*4] |=>
      pinOe[0] && pinOut[0] == $past(dedicated[0].level[0]))
    else $error("dedicated output lost");
  AST_MAP_UART: assert property (
    (selCodes[5:0] == 6'h01 && dedicated[0].enable == '0 &&
      !highCoreVoltageDetect) [*4] |=>
      pinOe[0] && pinOut[0] == $past(periph.uartATransmit))
    else $error("mapped transmit not on pin");
  AST_PORT_DIR: assert property (
    (selCodes[5:0] == 6'h02 && dedicated[0].enable == '0 &&
      !highCoreVoltageDetect) [*4] |=> pinOe[0] == !$past(pinDirection[0]))
    else $error("unassigned code not port");
  AST_ANALOG_GATE: assert property (
    analogSelect[0] [*2] |-> !digitalIn[0])
    else $error("analog pin reads digital");
endmodule
bind rpm_pin_mux rpm_pin_mux_properties chk (
  .mclk(mclk), .resetn(resetn), .selWrite(selWrite), .selData(selData),
  .periph(periph), .dedicated(dedicated),
  .highCoreVoltageDetect(highCoreVoltageDetect), .pinOut(pinOut),
  .pinOe(pinOe), .selCodes(selCodes), .pinDirection(pinDirection),
  .analogSelect(analogSelect), .digitalIn(digitalIn),
  .ioDisabled(ioDisabled));

// File: rpm_periph_model.sv
`timescale 1ns/100ps
module rpm_periph_model
  import rpm_pkg::*;
(
  // Clock and update
  input wire logic mclk,
  input wire logic load,
  input wire logic [66:0] val,
  // Sources
  output rpm_pkg::rpm_periph_t periph,
  output rpm_pkg::rpm_ded_t [rpm_pkg::NUM_PINS-1:0] dedicated
);
  import rpm_pkg::*;
  // Levels move only on command, so expected results stay fixed
  initial begin
    {periph, dedicated} = '0;
    forever begin
      @(posedge mclk);
      if (load) begin
        {periph, dedicated} <= val;
      end
    end
  end
endmodule

// File: rpm_pin_mux_tb.sv
`timescale 1ns/100ps
module rpm_pin_mux_tb;
  import rpm_pkg::*;
  logic mclk = 0, resetn = 0, load = 0, high_core_voltage_detect = 0;
  logic dirWrite = 0, analogWrite = 0, latchWrite = 0;
  logic [66:0] val = '0;
  logic [7:0] selWrite = '0, dirData = '0, analogData = '0, latchData = '0;
  logic [7:0] pinIn = '0, pinOut, pinOe, pinDirection, analogSelect;
  logic [7:0] outputLatch, pinLevel, digitalIn;
  logic [5:0] selData = '0;
  logic [47:0] selCodes;
  logic ioDisabled;
  rpm_periph_t periph;
  rpm_ded_t [7:0] dedicated;
  int mismatches = 0, testsRun = 0;
  always #2 mclk = ~mclk;
  rpm_periph_model partner (.mclk(mclk), .load(load), .val(val),
    .periph(periph), .dedicated(dedicated));
  rpm_pin_mux uut (.mclk(mclk), .resetn(resetn), .selWrite(selWrite),
    .selData(selData), .dirWrite(dirWrite), .dirData(dirData),
    .analogWrite(analogWrite), .analogData(analogData),
    .latchWrite(latchWrite), .latchData(latchData), .periph(periph),
    .dedicated(dedicated), .highCoreVoltageDetect(high_core_voltage_detect), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .selCodes(selCodes),
    .pinDirection(pinDirection), .analogSelect(analogSelect),
    .outputLatch(outputLatch), .pinLevel(pinLevel),
    .digitalIn(digitalIn), .ioDisabled(ioDisabled));
  task automatic cmp(logic [47:0] got, logic [47:0] exp);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Peripheral level picked by a select code; 1 in bit 1 when connected
  function automatic logic [1:0] mapOut(int c, rpm_periph_t p);
    case (c) inside
      1: return {1'b1, p.uartATransmit};
      3: return {1'b1, p.uartBTransmit};
      8: return {1'b1, p.spiBDataOut};
      9: return {1'b1, p.spiBClockOut};
      10: return {1'b1, p.spiBSelectOut};
      11: return {1'b1, p.codecDataOut};
      12: return {1'b1, p.codecClockOut};
      13: return {1'b1, p.codecFrameSyncOut};
      14: return {1'b1, p.canATransmit};
      15: return {1'b1, p.canBTransmit};
      [16:23]: return {1'b1, p.compareOut[c-16]};
      [24:26]: return {1'b1, p.comparatorOut[c-24]};
      27: return {1'b1, p.uartCTransmit};
      28: return {1'b1, p.uartCReadyToSend};
      29: return {1'b1, p.uartDTransmit};
      30: return {1'b1, p.uartDReadyToSend};
      31: return {1'b1, p.spiCDataOut};
      32: return {1'b1, p.spiCClockOut};
      33: return {1'b1, p.spiCSelectOut};
      45: return {1'b1, p.pwmPrimarySyncOut};
      46: return {1'b1, p.pwmSecondarySyncOut};
      47: return {1'b1, p.encoderACountMatchOut};
      48: return {1'b1, p.encoderBCountMatchOut};
      49: return {1'b1, p.referenceClockOut};
      [50:51]: return {1'b1, p.comparatorOut[c-47]};
      default: return 2'b00;
    endcase
  endfunction
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    logic [5:0] codes [8];
    logic [34:0] pv;
    logic [31:0] dv;
    logic [7:0] dir, ana, lat, eOe, eOut;
    logic [47:0] eSel;
    logic [1:0] m;
    logic [3:0] d;
    void'($urandom(13666));
    repeat (5) @(posedge mclk);
    resetn <= 1;
    @(posedge mclk);
    #1;
    cmp(selCodes, '0);
    cmp({pinDirection, analogSelect, outputLatch}, 24'hffff00);
    cmp({pinOe, digitalIn, pinLevel}, '0);
    $display("test reset done");
    for (int it = 0; it < 192; it++) begin
      for (int i = 0; i < 8; i++) begin
        codes[i] = (i == 0) ? 6'(it) : 6'($urandom);
        eSel[6*i +: 6] = codes[i];
      end
      pv = 35'({$urandom, $urandom});
      dv = $urandom & $urandom;
      if (it < 64) dv[3:0] = '0;
      {dir, ana, lat} = 24'($urandom);
      @(posedge mclk);
      load <= 1;
      val <= {pv, dv};
      dirWrite <= 1;
      dirData <= dir;
      analogWrite <= 1;
      analogData <= ana;
      latchWrite <= 1;
      latchData <= lat;
      pinIn <= 8'($urandom);
      high_core_voltage_detect <= (it >= 64) && ($urandom % 8 == 0);
      for (int i = 0; i < 8; i++) begin
        selWrite <= 8'(1 << i);
        selData <= codes[i];
        @(posedge mclk);
        {load, dirWrite, analogWrite, latchWrite} <= '0;
      end
      selWrite <= '0;
      repeat (5) @(posedge mclk);
      #1;
      for (int i = 0; i < 8; i++) begin
        d = dv[4*i +: 4];
        m = mapOut(codes[i], rpm_periph_t'(pv));
        if (d[2]) {eOe[i], eOut[i]} = {1'b1, d[0]};
        else if (d[3]) {eOe[i], eOut[i]} = {1'b1, d[1]};
        else if (m[1]) {eOe[i], eOut[i]} = m;
        else {eOe[i], eOut[i]} = {~dir[i], lat[i]};
        if (high_core_voltage_detect) {eOe[i], eOut[i]} = 2'b00;
      end
      cmp(selCodes, eSel);
      cmp(pinOe, eOe);
      cmp(pinOut, eOut);
      cmp({pinDirection, analogSelect, outputLatch},
        {dir, ana, lat & ~ana});
      cmp({digitalIn, pinLevel}, {2{pinIn & ~ana}});
      cmp(ioDisabled, high_core_voltage_detect);
    end
    $display("test routing done");
    final_report();
  end
endmodule
